/* verilog/sopg_top.sv */
// Strobe output pulse generator: event select, delay, lead, width, lines.
// Assumes synchronous inputs, one 250 MHz clock and a plain register port.
`timescale 1ns/100ps
`include "sopg_map.svh"

// Summary of operation
// - Timer source: software fire launches delayed pulse
// - Zero width: pulse follows exposure time
// - Nonzero width: pulse lasts width microseconds
// - Delay 0 to 10000 us before pulse
// - Lead time asserts strobe before exposure, exposure start source only
// - Disabled strobe drives no pulses
// - Line two selectable input or output
// - Line zero in, one out, two bidirectional
// - Polarity invert on lines one and two, off at reset
// - Selector picks launching internal event
module sopg_top #(
  parameter int CW = 20,
  parameter int NEVT = 13
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [NEVT-1:0] evt_i,
  input wire logic exp_req_i,
  input wire logic exposure_i,
  output logic exp_go_o,
  input wire logic line0_i,
  output logic line1_o,
  input wire logic line2_i,
  output logic line2_o,
  output logic line2_oe_o,
  output logic trig_line0_o,
  output logic trig_line2_o
);

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] ctrl_reg; // Enable, direction, inverts, source
  logic [7:0] ctrl_next;
  logic [CW-1:0] wid_reg; // Width in us, zero follows exposure
  logic [CW-1:0] wid_next;
  logic [CW-1:0] dly_reg; // Delay in us, clamped
  logic [CW-1:0] dly_next;
  logic [CW-1:0] pre_reg; // Lead time in us
  logic [CW-1:0] pre_next;
  logic [31:0] rdata_reg; // Read data, one cycle after strobe
  logic [31:0] rdata_next;

  logic en; // Strobe enabled
  logic dir2; // Line two drives
  logic inv1; // Line one inverted
  logic inv2; // Line two inverted
  sopg_pkg::sopg_src_t src; // Selected source
  logic fire; // Software line fire command

  assign en = ctrl_reg[`SOPG_CTRL_EN];
  assign dir2 = ctrl_reg[`SOPG_CTRL_DIR2];
  assign inv1 = ctrl_reg[`SOPG_CTRL_INV1];
  assign inv2 = ctrl_reg[`SOPG_CTRL_INV2];
  assign src = sopg_pkg::sopg_src_t'(
    ctrl_reg[`SOPG_CTRL_SRC_HI:`SOPG_CTRL_SRC_LO]);
  assign fire = wr_i && addr_i == `SOPG_ADDR_CMD && wdata_i[`SOPG_CMD_FIRE];

  // Clamp a written delay so the pulse never waits past the limit
  function automatic logic [CW-1:0] clamp_dly(input logic [31:0] v);
    if (v > `SOPG_DLY_MAX_US) begin
      clamp_dly = CW'(`SOPG_DLY_MAX_US);
    end else begin
      clamp_dly = v[CW-1:0];
    end
  endfunction : clamp_dly

  sopg_pkg::sopg_state_t st_reg; // Sequencer state
  sopg_pkg::sopg_state_t st_next;
  logic strobe_act; // Strobe asserted this cycle

  // Register writes and reads
  always_comb begin
    ctrl_next = ctrl_reg;
    wid_next = wid_reg;
    dly_next = dly_reg;
    pre_next = pre_reg;
    rdata_next = 32'h00000000;
    if (wr_i) begin
      if (addr_i == `SOPG_ADDR_CTRL) begin
        ctrl_next = wdata_i[7:0];
      end else if (addr_i == `SOPG_ADDR_WIDTH) begin
        wid_next = wdata_i[CW-1:0];
      end else if (addr_i == `SOPG_ADDR_DELAY) begin
        dly_next = clamp_dly(wdata_i);
      end else if (addr_i == `SOPG_ADDR_LEAD) begin
        pre_next = wdata_i[CW-1:0];
      end
    end
    if (rd_i) begin
      if (addr_i == `SOPG_ADDR_CTRL) begin
        rdata_next = {24'h000000, ctrl_reg};
      end else if (addr_i == `SOPG_ADDR_WIDTH) begin
        rdata_next = 32'(wid_reg);
      end else if (addr_i == `SOPG_ADDR_DELAY) begin
        rdata_next = 32'(dly_reg);
      end else if (addr_i == `SOPG_ADDR_LEAD) begin
        rdata_next = 32'(pre_reg);
      end else if (addr_i == `SOPG_ADDR_STAT) begin
        rdata_next[`SOPG_STAT_BUSY] = st_reg != sopg_pkg::SOPG_IDLE;
        rdata_next[`SOPG_STAT_ACT] = strobe_act;
        rdata_next[`SOPG_STAT_LINE0] = line0_i;
        rdata_next[`SOPG_STAT_LINE2] = line2_i;
        rdata_next[`SOPG_STAT_EXPO] = exposure_i;
      end else begin
        // Unmapped and command reads return zero
        rdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= `SOPG_CTRL_RST;
      wid_reg <= CW'(`SOPG_TIME_RST);
      dly_reg <= CW'(`SOPG_TIME_RST);
      pre_reg <= CW'(`SOPG_TIME_RST);
      rdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      wid_reg <= wid_next;
      dly_reg <= dly_next;
      pre_reg <= pre_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pulse sequencer

  logic [CW-1:0] cnt_reg; // Elapsed microseconds in the state
  logic [CW-1:0] cnt_next;
  logic expo_q_reg; // Exposure level one cycle back
  logic us_tick; // One-cycle pulse per microsecond
  logic sel_evt; // Selected launching event
  logic lead_mode; // Lead time armed
  logic lead_take; // Exposure request captured for lead
  logic lead_done; // Lead time elapsed
  logic expo_fall; // Exposure just ended

  assign sel_evt = evt_i[src] ||
    (fire && src == sopg_pkg::SOPG_SRC_TIMER);
  assign lead_mode = pre_reg != '0 && src == sopg_pkg::SOPG_SRC_EXP_START;
  assign lead_take = st_reg == sopg_pkg::SOPG_IDLE && en && lead_mode &&
    exp_req_i;
  assign lead_done = st_reg == sopg_pkg::SOPG_LEAD && us_tick &&
    cnt_reg == pre_reg - 1'b1;
  assign expo_fall = expo_q_reg && !exposure_i;
  assign strobe_act = st_reg == sopg_pkg::SOPG_ACTIVE ||
    st_reg == sopg_pkg::SOPG_LEAD;

  // microsecond timebase, restarted at each state change
  sopg_tick sopg_tick_inst (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(st_next != st_reg),
    .tick_o(us_tick)
  );

  // Next state; events while busy are dropped, not queued
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      sopg_pkg::SOPG_IDLE: begin
        if (lead_take) begin
          st_next = sopg_pkg::SOPG_LEAD;
        end else if (en && !lead_mode && sel_evt) begin
          st_next = dly_reg == '0 ? sopg_pkg::SOPG_ACTIVE :
            sopg_pkg::SOPG_DELAY;
        end
      end
      sopg_pkg::SOPG_DELAY: begin
        if (us_tick && cnt_reg == dly_reg - 1'b1) begin
          st_next = sopg_pkg::SOPG_ACTIVE;
        end
      end
      sopg_pkg::SOPG_LEAD: begin
        if (lead_done) begin
          st_next = sopg_pkg::SOPG_ACTIVE;
        end
      end
      sopg_pkg::SOPG_ACTIVE: begin
        if (wid_reg == '0) begin
          if (expo_fall) begin
            st_next = sopg_pkg::SOPG_IDLE;
          end
        end else if (us_tick && cnt_reg == wid_reg - 1'b1) begin
          st_next = sopg_pkg::SOPG_IDLE;
        end
      end
      default: begin
        st_next = sopg_pkg::SOPG_IDLE;
      end
    endcase
    if (!en) begin
      st_next = sopg_pkg::SOPG_IDLE;
    end
  end

  // Microsecond counter within each state
  always_comb begin
    if (st_next != st_reg) begin
      cnt_next = '0;
    end else if (us_tick) begin
      cnt_next = cnt_reg + 1'b1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= sopg_pkg::SOPG_IDLE;
      cnt_reg <= '0;
      expo_q_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      expo_q_reg <= exposure_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lines and exposure release

  logic line1_next;
  logic line2_next;
  logic oe2_next;
  logic go_next;
  logic trig0_next;
  logic trig2_next;
  logic line1_reg;
  logic line2_reg;
  logic oe2_reg;
  logic go_reg;
  logic trig0_reg;
  logic trig2_reg;

  // Line levels; the idle level follows the invert setting
  always_comb begin
    line1_next = strobe_act ^ inv1;
    line2_next = strobe_act ^ inv2;
    oe2_next = dir2;
    trig2_next = !dir2 && line2_i;
    trig0_next = line0_i;
    go_next = (exp_req_i && !lead_take) || lead_done;
  end

  // Output flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line1_reg <= 1'b0;
      line2_reg <= 1'b0;
      oe2_reg <= 1'b0;
      go_reg <= 1'b0;
      trig0_reg <= 1'b0;
      trig2_reg <= 1'b0;
    end else begin
      line1_reg <= line1_next;
      line2_reg <= line2_next;
      oe2_reg <= oe2_next;
      go_reg <= go_next;
      trig0_reg <= trig0_next;
      trig2_reg <= trig2_next;
    end
  end

  assign line1_o = line1_reg;
  assign line2_o = line2_reg;
  assign line2_oe_o = oe2_reg;
  assign exp_go_o = go_reg;
  assign trig_line0_o = trig0_reg;
  assign trig_line2_o = trig2_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_fire;
    (st_reg == sopg_pkg::SOPG_IDLE && en && fire && !lead_mode &&
     src == sopg_pkg::SOPG_SRC_TIMER) |=> st_reg != sopg_pkg::SOPG_IDLE;
  endproperty
  a_fire: assert property (p_fire) else $error("fire not launched");

  property p_expo_end;
    (st_reg == sopg_pkg::SOPG_ACTIVE && en && wid_reg == '0 && expo_fall)
      |=> st_reg == sopg_pkg::SOPG_IDLE ##1 !line1_o == !inv1;
  endproperty
  a_expo_end: assert property (p_expo_end) else $error("no end");

  property p_width;
    (st_reg == sopg_pkg::SOPG_ACTIVE && wid_reg != '0 && en &&
     !(us_tick && cnt_reg == wid_reg - 1'b1)) |=>
      st_reg == sopg_pkg::SOPG_ACTIVE;
  endproperty
  a_width: assert property (p_width) else $error("pulse cut");

  property p_dly_max;
    dly_reg <= CW'(`SOPG_DLY_MAX_US);
  endproperty
  a_dly_max: assert property (p_dly_max) else $error("delay over");

  property p_lead;
    lead_take |=> strobe_act && !exp_go_o;
  endproperty
  a_lead: assert property (p_lead) else $error("lead order");

  property p_disable;
    !en |=> st_reg == sopg_pkg::SOPG_IDLE ##1 line1_o == $past(inv1);
  endproperty
  a_disable: assert property (p_disable) else $error("pulse off");

  property p_dir;
    !dir2 ##1 !dir2 |-> !line2_oe_o;
  endproperty
  a_dir: assert property (p_dir) else $error("line2 driven");

  property p_trig0;
    line0_i |=> trig_line0_o;
  endproperty
  a_trig0: assert property (p_trig0) else $error("line0 lost");

  property p_inv;
    st_reg == sopg_pkg::SOPG_IDLE |=> line1_o == $past(inv1);
  endproperty
  a_inv: assert property (p_inv) else $error("idle level");

  property p_sel;
    (st_reg == sopg_pkg::SOPG_IDLE && en && !lead_mode && !evt_i[src] &&
     !fire) |=> st_reg == sopg_pkg::SOPG_IDLE;
  endproperty
  a_sel: assert property (p_sel) else $error("stray launch");

  property p_busy;
    (st_reg == sopg_pkg::SOPG_DELAY && en && sel_evt && !us_tick) |=>
      st_reg == sopg_pkg::SOPG_DELAY && $stable(cnt_reg);
  endproperty
  a_busy: assert property (p_busy) else $error("restart");

endmodule : sopg_top

/* verilog/sopg_map.svh */
// Address map, field positions, reset values and timing figures of the
// strobe pulse generator. Assumes the includer sits in a 250 MHz domain.
`ifndef SOPG_MAP_SVH
`define SOPG_MAP_SVH

// Register byte addresses
`define SOPG_ADDR_CTRL 8'h00
`define SOPG_ADDR_WIDTH 8'h04
`define SOPG_ADDR_DELAY 8'h08
`define SOPG_ADDR_LEAD 8'h0C
`define SOPG_ADDR_CMD 8'h10
`define SOPG_ADDR_STAT 8'h14

// Control register fields
`define SOPG_CTRL_EN 0
`define SOPG_CTRL_DIR2 1
`define SOPG_CTRL_INV1 2
`define SOPG_CTRL_INV2 3
`define SOPG_CTRL_SRC_LO 4
`define SOPG_CTRL_SRC_HI 7

// Command register fields
`define SOPG_CMD_FIRE 0

// Status register fields
`define SOPG_STAT_BUSY 0
`define SOPG_STAT_ACT 1
`define SOPG_STAT_LINE0 2
`define SOPG_STAT_LINE2 3
`define SOPG_STAT_EXPO 4

// Reset values
`define SOPG_CTRL_RST 8'h00
`define SOPG_TIME_RST 20'h00000

// Timing figures
`define SOPG_CLK_PERIOD_NS 4
`define SOPG_US_NS 1000
`define SOPG_DLY_MAX_US 32'h00002710

`endif

/* verilog/sopg_pkg.sv */
// Types shared by the strobe pulse generator files.
// Assumes the map header supplies all numeric constants.
package sopg_pkg;

  // Pulse sequencer states
  typedef enum logic [1:0] {
    SOPG_IDLE,
    SOPG_DELAY,
    SOPG_LEAD,
    SOPG_ACTIVE
  } sopg_state_t;

  // Launching event sources, in the order of the event input vector
  typedef enum logic [3:0] {
    SOPG_SRC_EXP_START,
    SOPG_SRC_EXP_END,
    SOPG_SRC_ACQ_START,
    SOPG_SRC_ACQ_STOP,
    SOPG_SRC_BURST_START,
    SOPG_SRC_BURST_END,
    SOPG_SRC_TRIG_WAIT,
    SOPG_SRC_FRAME_START,
    SOPG_SRC_FRAME_END,
    SOPG_SRC_SOFT_TRIG,
    SOPG_SRC_HARD_TRIG,
    SOPG_SRC_COUNTER,
    SOPG_SRC_TIMER
  } sopg_src_t;

endpackage : sopg_pkg

/* verilog/sopg_tick.sv */
// Microsecond tick generator for the strobe pulse generator.
// Assumes one clock; a synchronous clear restarts the microsecond phase.
`timescale 1ns/100ps
`include "sopg_map.svh"

module sopg_tick #(
  parameter int DIV = `SOPG_US_NS / `SOPG_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  output logic tick_o
);

  localparam int PW = $clog2(DIV);

  // Cycle count within the current microsecond
  logic [PW-1:0] ph_reg;
  logic [PW-1:0] ph_next;

  // Restart on clear so counted intervals are whole microseconds
  always_comb begin
    if (clr_i || ph_reg == PW'(DIV - 1)) begin
      ph_next = '0;
    end else begin
      ph_next = ph_reg + 1'b1;
    end
  end

  // Phase register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_reg <= '0;
    end else begin
      ph_reg <= ph_next;
    end
  end

  // Tick marks the last cycle of each microsecond. Not gated by the
  // clear: the clear is decoded from the tick, so gating would loop.
  assign tick_o = ph_reg == PW'(DIV - 1);

endmodule : sopg_tick

/* bench/sopg_partner.sv */
// Far-side model: light controller timing line one, driving line two.
// Assumes the bench resolves line two from both output enables.
`timescale 1ns/100ps
module sopg_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic line1_i,
  input wire logic line2_oe_i,
  input wire logic lvl_i,
  output logic drv_o,
  output logic drv_oe_o,
  output logic [19:0] width_o
);
  logic [19:0] cnt_reg; // Cycles high so far
  logic [19:0] cnt_next;
  logic [19:0] width_reg; // Length of last finished pulse
  logic [19:0] width_next;

  ////////////////////////////////////////////////////////////////////////
  // driver released
  // Drives only while the block listens, so the pads never fight
  assign drv_oe_o = !line2_oe_i;
  assign drv_o = lvl_i;

  ////////////////////////////////////////////////////////////////////////
  // pulse length
  always_comb begin
    cnt_next = line1_i ? cnt_reg + 20'h00001 : 20'h00000;
    width_next = width_reg;
    if (!line1_i && cnt_reg != 20'h00000) begin
      width_next = cnt_reg;
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 20'h00000;
      width_reg <= 20'h00000;
    end else begin
      cnt_reg <= cnt_next;
      width_reg <= width_next;
    end
  end
  assign width_o = width_reg;
endmodule : sopg_partner

/* bench/test_sopg_top.sv */
// Self-checking bench of the strobe pulse generator.
// Assumes the 250 cycles a microsecond tick of the design.
`timescale 1ns/100ps
`include "sopg_map.svh"
module test_sopg_top;
  logic clk_i, rst_n_i, wr_i, rd_i, exp_req_i, exposure_i;
  logic line0_i, p_lvl, p_drv, p_oe;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, got;
  logic [12:0] evt_i;
  logic exp_go_o, line1_o, line2_o, line2_oe_o;
  logic trig_line0_o, trig_line2_o;
  logic [19:0] p_width;
  wire line2_w = line2_oe_o ? line2_o : (p_oe ? p_drv : 1'b0);
  int n_errors, num_checks, cyc, n;

  sopg_top sopg_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .evt_i(evt_i), .exp_req_i(exp_req_i),
    .exposure_i(exposure_i), .exp_go_o(exp_go_o), .line0_i(line0_i),
    .line1_o(line1_o), .line2_i(line2_w), .line2_o(line2_o),
    .line2_oe_o(line2_oe_o), .trig_line0_o(trig_line0_o),
    .trig_line2_o(trig_line2_o));
  sopg_partner sopg_partner_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .line1_i(line1_o), .line2_oe_i(line2_oe_o), .lvl_i(p_lvl),
    .drv_o(p_drv), .drv_oe_o(p_oe), .width_o(p_width));

  ////////////////////////////////////////////////////////////////////////
  // Verdict, counts and hang guard
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Ceiling well above the few thousand cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus and stimulus helpers; requests change just after an edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    got = rdata_o;
  endtask : rd

  task evt(input int s);
    @(posedge clk_i);
    evt_i[s] <= 1'b1;
    @(posedge clk_i);
    evt_i <= 13'h0000;
  endtask : evt

  // Counts falling edges until line one shows v, at most m
  task wait_lvl(input logic v, input int m);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (line1_o !== v && n < m);
  endtask : wait_lvl

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    check({line1_o, line2_o, line2_oe_o, exp_go_o}, 0);
    rd(`SOPG_ADDR_CTRL);
    check(got, 0);
    rd(8'h20);
    check(got, 0);
  endtask : t_reset

  task t_timer;
    wr(`SOPG_ADDR_DELAY, 32'h00004E20);
    rd(`SOPG_ADDR_DELAY);
    check(got, `SOPG_DLY_MAX_US);
    wr(`SOPG_ADDR_DELAY, 32'h00000001);
    wr(`SOPG_ADDR_WIDTH, 32'h00000001);
    wr(`SOPG_ADDR_CTRL, 32'h000000C1);
    wr(`SOPG_ADDR_CMD, 32'h00000001);
    // Second fire lands inside the delay and must not restart it
    wr(`SOPG_ADDR_CMD, 32'h00000001);
    wait_lvl(1'b1, 600);
    check(n, 250);
    wait_lvl(1'b0, 600);
    check(n, 250);
    @(negedge clk_i);
    check(p_width, 250);
    wr(`SOPG_ADDR_DELAY, 32'h00000000);
  endtask : t_timer

  task t_sel;
    for (int s = 0; s < 13; s++) begin
      wr(`SOPG_ADDR_CTRL, (s << 4) | 1);
      evt((s + 1) % 13);
      wait_lvl(1'b1, 5);
      check(line1_o, 0);
      evt(s);
      wait_lvl(1'b1, 10);
      check(n, 2);
      evt(s);
      wait_lvl(1'b0, 400);
      check(n, 249);
      wait_lvl(1'b1, 6);
      check(line1_o, 0);
    end
  endtask : t_sel

  task t_width0;
    wr(`SOPG_ADDR_WIDTH, 32'h00000000);
    wr(`SOPG_ADDR_CTRL, 32'h00000081);
    exposure_i <= 1'b1;
    evt(8);
    wait_lvl(1'b1, 10);
    rd(`SOPG_ADDR_STAT);
    check(got[4:0], 5'b10011);
    repeat (38) @(posedge clk_i);
    exposure_i <= 1'b0;
    wait_lvl(1'b0, 10);
    check(n, 3);
    @(negedge clk_i);
    check(p_width, 42);
  endtask : t_width0

  task t_lead;
    wr(`SOPG_ADDR_WIDTH, 32'h00000001);
    wr(`SOPG_ADDR_LEAD, 32'h00000001);
    wr(`SOPG_ADDR_CTRL, 32'h00000001);
    @(posedge clk_i);
    exp_req_i <= 1'b1;
    @(posedge clk_i);
    exp_req_i <= 1'b0;
    wait_lvl(1'b1, 10);
    check(n, 2);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (exp_go_o !== 1'b1 && n < 400);
    check(n, 249);
    check(line1_o, 1);
    wait_lvl(1'b0, 400);
    wr(`SOPG_ADDR_LEAD, 32'h00000000);
    @(posedge clk_i);
    exp_req_i <= 1'b1;
    @(posedge clk_i);
    exp_req_i <= 1'b0;
    @(negedge clk_i);
    check(exp_go_o, 1);
  endtask : t_lead

  task t_disable;
    wr(`SOPG_ADDR_CTRL, 32'h00000004);
    evt(0);
    wr(`SOPG_ADDR_CMD, 32'h00000001);
    repeat (4) @(negedge clk_i);
    check(line1_o, 1);
    wr(`SOPG_ADDR_CTRL, 32'h00000001);
    evt(0);
    wait_lvl(1'b1, 10);
    wr(`SOPG_ADDR_CTRL, 32'h00000000);
    wait_lvl(1'b0, 6);
    check(n, 3);
    rd(`SOPG_ADDR_STAT);
    check(got[0], 0);
  endtask : t_disable

  task t_line2;
    wr(`SOPG_ADDR_CTRL, 32'h0000000B);
    repeat (2) @(negedge clk_i);
    check({line2_oe_o, line2_o, trig_line2_o}, 3'b110);
    evt(0);
    repeat (3) @(negedge clk_i);
    check({line1_o, line2_o}, 2'b10);
    wait_lvl(1'b0, 400);
    wr(`SOPG_ADDR_CTRL, 32'h00000000);
    p_lvl <= 1'b1;
    line0_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    check({line2_oe_o, trig_line2_o, trig_line0_o}, 3'b011);
    rd(`SOPG_ADDR_STAT);
    check(got[3:2], 2'b11);
  endtask : t_line2

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    {wr_i, rd_i, exp_req_i, exposure_i, line0_i, p_lvl} = 6'h00;
    addr_i = 8'h00;
    wdata_i = 32'h00000000;
    evt_i = 13'h0000;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    t_reset();
    t_timer();
    t_sel();
    t_width0();
    t_lead();
    t_disable();
    t_line2();
    close_out();
  end
endmodule : test_sopg_top
